// >>> pkg/vsd_map.svh
// timing and level constants for the vertical sync detector
`ifndef VSD_MAP_SVH
`define VSD_MAP_SVH

// system clock period, picoseconds (200 MHz)
`define VSD_CLK_PERIOD_PS 5000
// vertical output width, eight oscillator periods, microseconds
`define VSD_VPULSE_US 230
`define VSD_OSC_DIV 8
`define VSD_OSC_CYC ((`VSD_VPULSE_US * 1000000 / `VSD_OSC_DIV) / `VSD_CLK_PERIOD_PS)
// default trigger delay from start of vertical sync, microseconds
`define VSD_DEFAULT_US 65
`define VSD_DFLT_CYC (`VSD_DEFAULT_US * 1000000 / `VSD_CLK_PERIOD_PS)
// integrated sync time that marks a broad vertical pulse, microseconds
`define VSD_SERR_US 10
`define VSD_SERR_CYC (`VSD_SERR_US * 1000000 / `VSD_CLK_PERIOD_PS)
// sync-free gap that counts as a whole line for the field toggle, microseconds
`define VSD_GAP_US 45
`define VSD_GAP_CYC (`VSD_GAP_US * 1000000 / `VSD_CLK_PERIOD_PS)
// slicer offset above the clamped tip, millivolts, and sample weight, microvolts
`define VSD_SLICE_MV 70
`define VSD_LSB_UV 8000
`define VSD_SLICE_CODES (`VSD_SLICE_MV * 1000 / `VSD_LSB_UV)
// tip clamp leak interval, cycles per code
`define VSD_TIP_LEAK_CYC 256
// tip reset value and integrator charge step per cycle
`define VSD_TIP_RST 8'hff
`define VSD_CHARGE_RATE 1

`endif

// >>> pkg/vsd_pkg.sv
// types shared by the vertical sync detector
package vsd_pkg;
    // integrator comparator results
    typedef struct packed {
        logic above_serr;
        logic above_dflt;
    } vsd_cmp_s;
    // trigger sources feeding the pulse flag
    typedef struct packed {
        logic serration;
        logic dflt;
    } vsd_trig_s;
    typedef logic [23:0] vsd_cnt_t;
endpackage

// >>> logic/vsd_osc.sv
// pulse-width oscillator with divide-by-eight
`timescale 1ns/1ps
`include "vsd_map.svh"
module vsd_osc #(
    parameter int OSC_CYC = `VSD_OSC_CYC
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // control and completion
    input wire logic en_in,
    output logic done_out
);
    import vsd_pkg::*;

    logic [15:0] per;
    logic [2:0] div;
    wire tick = (per == 16'(OSC_CYC - 1));

    // counters sit at zero while disabled so each pulse starts fresh
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            per <= 16'h0;
            div <= 3'h0;
        end else if (!en_in) begin
            per <= 16'h0;
            div <= 3'h0;
        end else begin
            per <= tick ? 16'h0 : per + 16'h1;
            div <= tick ? div + 3'h1 : div;
        end
    end

    // eighth period completes the pulse
    assign done_out = en_in && tick && (div == 3'h7);

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_start_clear;
        $rose(en_in) |-> (per == 16'h0) && (div == 3'h0);
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("osc not cleared at start");
endmodule

// >>> logic/vsd_vsync.sv
// composite sync slicer, vertical sync detector and field index
`timescale 1ns/1ps
`include "vsd_map.svh"

module vsd_vsync #(
    parameter int SAMPLE_W = 8,
    parameter int OSC_CYC = `VSD_OSC_CYC,
    parameter vsd_pkg::vsd_cnt_t SERR_LVL = 24'(`VSD_SERR_CYC),
    parameter vsd_pkg::vsd_cnt_t DFLT_LVL = 24'(`VSD_DFLT_CYC),
    parameter vsd_pkg::vsd_cnt_t CHARGE_RATE = 24'(`VSD_CHARGE_RATE),
    parameter vsd_pkg::vsd_cnt_t GAP_CYC = 24'(`VSD_GAP_CYC),
    parameter int SLICE_OFS = `VSD_SLICE_CODES,
    parameter int TIP_LEAK_CYC = `VSD_TIP_LEAK_CYC
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // digitised composite video, negative-going sync
    input wire logic [SAMPLE_W-1:0] video_in,
    // sync outputs
    output logic csync_out,
    output logic vsync_out,
    output logic field_odd_out
);
    import vsd_pkg::*;

    localparam int PULSE_CYC = `VSD_OSC_DIV * OSC_CYC;
    localparam vsd_cnt_t CNT_MAX = 24'hffffff;

    // saturating add shared by integrator, gap and width counters
    function automatic vsd_cnt_t sat_add(input vsd_cnt_t v, input vsd_cnt_t step);
        sat_add = (v > CNT_MAX - step) ? CNT_MAX : v + step;
    endfunction

    logic [SAMPLE_W-1:0] tip;
    logic [15:0] leak;
    logic csync_d;
    vsd_cnt_t integ;
    vsd_cnt_t gap;
    logic dflt_d;
    vsd_trig_s trig;
    logic tog;
    logic osc_done;

    // slicer: fixed offset over the tip, so level is amplitude independent
    wire [SAMPLE_W:0] slice_lvl = {1'b0, tip} + (SAMPLE_W+1)'(SLICE_OFS);
    wire sliced = ({1'b0, video_in} < slice_lvl);
    wire leak_tick = (leak == 16'(TIP_LEAK_CYC - 1));
    wire sync_fall = csync_d && !csync_out;
    wire sync_rise = csync_out && !csync_d;

    // integrator comparators
    vsd_cmp_s cmp;
    // one driver for the whole struct keeps strict elaborators happy
    assign cmp = '{above_serr: (integ > SERR_LVL), above_dflt: (integ >= DFLT_LVL)};

    // flag control: either trigger sets, but only an idle flag
    wire any_trig = trig.serration || trig.dflt;
    wire set_flag = any_trig && !vsync_out;
    wire next_flag = osc_done ? 1'b0 : (set_flag ? 1'b1 : vsync_out);

    // tip clamp: follows down at once, leaks up slowly like a coupling cap
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tip <= SAMPLE_W'(`VSD_TIP_RST);
            leak <= 16'h0;
        end else begin
            leak <= leak_tick ? 16'h0 : leak + 16'h1;
            if (video_in < tip) begin
                tip <= video_in;
            end else if (leak_tick && tip != {SAMPLE_W{1'b1}}) begin
                tip <= tip + SAMPLE_W'(1);
            end
        end
    end

    // sliced sync register and its delayed copy for edge detection
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            csync_out <= 1'b0;
            csync_d <= 1'b0;
        end else begin
            csync_out <= sliced;
            csync_d <= csync_out;
        end
    end

    // integrator charges during sync and dumps between pulses
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            integ <= 24'h0;
        end else begin
            integ <= csync_out ? sat_add(integ, CHARGE_RATE) : 24'h0;
        end
    end

    // trigger latches: serration on trailing edge, default on threshold crossing
    // the default fires on the crossing only, so a pulse that ends mid-sync
    // is followed by the trailing-edge trigger rather than an instant repeat
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trig <= '0;
            dflt_d <= 1'b0;
        end else begin
            trig.serration <= sync_fall && cmp.above_serr;
            trig.dflt <= cmp.above_dflt && !dflt_d;
            dflt_d <= cmp.above_dflt;
        end
    end

    // vertical pulse flag
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vsync_out <= 1'b0;
        end else begin
            vsync_out <= next_flag;
        end
    end

    vsd_osc #(
        .OSC_CYC(OSC_CYC)
    ) u_osc (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .en_in(vsync_out),
        .done_out(osc_done)
    );

    // field toggle: cleared by a full-line gap, flipped by each half-line gap
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap <= 24'h0;
            tog <= 1'b0;
        end else begin
            gap <= csync_out ? 24'h0 : sat_add(gap, 24'h1);
            if (sync_rise) begin
                tog <= (gap >= GAP_CYC) ? 1'b0 : !tog;
            end
        end
    end

    // field index resolved when the pulse flag is set
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            field_odd_out <= 1'b0;
        end else if (set_flag) begin
            field_odd_out <= tog;
        end
    end

    // checking helper: cycles the current pulse has lasted
    vsd_cnt_t hi_len;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hi_len <= 24'h0;
        end else begin
            hi_len <= vsync_out ? sat_add(hi_len, 24'h1) : 24'h0;
        end
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_serr_edge;
        sync_fall && cmp.above_serr && !vsync_out && !osc_done;
    endsequence
    sequence s_flag_set;
        trig.serration ##1 vsync_out;
    endsequence

    property p_serr_start;
        s_serr_edge |=> s_flag_set;
    endproperty
    a_serr_start: assert property (p_serr_start) else $error("serration edge did not start pulse");

    property p_no_low_trig;
        sync_fall && !cmp.above_serr |=> !trig.serration;
    endproperty
    a_no_low_trig: assert property (p_no_low_trig) else $error("serration trigger below level");

    property p_integ_dump;
        !csync_out |=> integ == 24'h0;
    endproperty
    a_integ_dump: assert property (p_integ_dump) else $error("integrator charged outside sync");

    property p_width;
        $fell(vsync_out) |-> hi_len == 24'(PULSE_CYC);
    endproperty
    a_width: assert property (p_width) else $error("vertical pulse width wrong");

    property p_no_extend;
        hi_len <= 24'(PULSE_CYC);
    endproperty
    a_no_extend: assert property (p_no_extend) else $error("pulse extended by trigger");

    property p_default;
        $rose(cmp.above_dflt) && !vsync_out && !trig.serration |=> ##1 vsync_out;
    endproperty
    a_default: assert property (p_default) else $error("default pulse not started");

    property p_field;
        $rose(vsync_out) |-> field_odd_out == $past(tog);
    endproperty
    a_field: assert property (p_field) else $error("field index not taken at pulse");

    property p_clamp;
        video_in < tip |=> tip == $past(video_in);
    endproperty
    a_clamp: assert property (p_clamp) else $error("tip clamp missed");

    property p_done_clears;
        osc_done |=> !vsync_out;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("flag not cleared");
endmodule

// >>> testbench/vsd_video_src.sv
// composite video source model with negative-going sync
`timescale 1ns/1ps
module vsd_video_src (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // sync request from the bench, video sample out
    input wire logic sync_req_in,
    output logic [7:0] video_out
);
    logic [6:0] pic;
    // picture sweeps above black every cycle, so leaked picture shows up as sync
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pic <= 7'h00;
        end else begin
            pic <= pic + 7'h01;
        end
    end
    // tip well below black; broad pulses are held by the bench
    assign video_out = sync_req_in ? 8'h10 : (8'h40 + {1'b0, pic});
endmodule

// >>> testbench/test_vsd_vsync.sv
// self-checking bench for the vertical sync detector
`timescale 1ns/1ps
module test_vsd_vsync;
    import vsd_pkg::*;
    localparam int OSC = 4;
    localparam int WID = 8 * OSC;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sync_req = 1'b0;
    logic [7:0] video;
    logic csync, vsync, field, vsync_d;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    int pulses = 0;

    initial forever #2.5 mclk_in = ~mclk_in;

    vsd_video_src vsd_video_src_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .sync_req_in(sync_req), .video_out(video));
    // short counts keep the run brief; serration level stays below default
    vsd_vsync #(.OSC_CYC(OSC), .SERR_LVL(24'h14), .DFLT_LVL(24'h3c), .GAP_CYC(24'h28),
        .TIP_LEAK_CYC(16)) vsd_vsync_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .video_in(video), .csync_out(csync), .vsync_out(vsync), .field_odd_out(field));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // rising edges of the vertical output, to catch duplicates or lost pulses
    always @(posedge mclk_in) begin
        vsync_d <= vsync;
        if (vsync === 1'b1 && vsync_d !== 1'b1) pulses++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge mclk_in);
    endtask

    // sync held n cycles; returns at the edge that releases it
    task automatic sync_for(input int n);
        @(posedge mclk_in);
        sync_req <= 1'b1;
        repeat (n) @(posedge mclk_in);
        sync_req <= 1'b0;
    endtask

    task automatic wait_rise(output int n);
        n = 0;
        while (vsync !== 1'b1 && n < 200) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
    endtask

    task automatic width(output int w);
        w = 0;
        while (vsync === 1'b1 && w < 300) begin
            @(posedge mclk_in);
            #1;
            w++;
        end
    endtask

    task automatic t_csync();
        int i;
        sync_for(3);
        // the releasing edge still samples sync, so csync shows it until the next edge
        #1;
        check(csync, 1);
        @(posedge mclk_in);
        #1;
        for (i = 0; i < 20; i++) begin
            check(csync, 0);
            @(posedge mclk_in);
            #1;
        end
    endtask

    // sync too short to pass the serration level never gives a pulse
    task automatic t_short();
        int p;
        p = pulses;
        repeat (4) begin
            sync_for(15);
            idle(40);
        end
        check(pulses, p);
    endtask

    task automatic t_serr();
        int n, w, p;
        idle(60);
        p = pulses;
        sync_for(30);
        wait_rise(n);
        check(n, 3);
        check(field, 0);
        width(w);
        check(w, WID);
        idle(10);
        check(pulses, p + 1);
    endtask

    // serration inside a pulse is ignored, a later one restarts it
    task automatic t_retrig();
        int n, w, p;
        idle(60);
        sync_for(4);
        idle(20);
        // count taken before the pulse: the counter only sees the rise one edge later
        p = pulses;
        sync_for(30);
        wait_rise(n);
        check(field, 1);
        fork
            width(w);
            begin
                idle(2);
                sync_for(22);
            end
        join
        check(w, WID);
        check(pulses, p + 1);
        idle(5);
        sync_for(30);
        wait_rise(n);
        check(n, 3);
        width(w);
        check(w, WID);
    endtask

    // long sync without serrations: default pulse, then one at the trailing edge
    task automatic t_dflt();
        int n, w;
        idle(60);
        @(posedge mclk_in);
        sync_req <= 1'b1;
        wait_rise(n);
        check(n >= 61 && n <= 65, 1);
        width(w);
        check(w, WID);
        idle(25);
        sync_req <= 1'b0;
        wait_rise(n);
        check(n, 3);
        width(w);
        check(w, WID);
    endtask

    initial begin
        repeat (12) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        check(vsync, 0);
        t_csync();
        t_short();
        t_serr();
        t_retrig();
        t_dflt();
        wrap_up();
    end
endmodule
